/* File: rtl/suif_pkg.sv */
// Shared constants of the SPI front end, holding registers and infrared codec.
// Assumes one 40 MHz reference clock; every user writes suif_pkg::name.
`default_nettype none

package suif_pkg;

  // ----------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------
  localparam int          CMD_RW_BIT = 7;
  localparam int          CMD_IDX_HI = 6;
  localparam int          CMD_IDX_LO = 3;
  localparam int          CMD_CH_HI  = 2;
  localparam int          CMD_CH_LO  = 1;
  localparam logic [1:0]  CH_A       = 2'h0;
  localparam logic [1:0]  CH_B       = 2'h1;

  // ----------------------------------------------------------------
  // Register indices and fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_HOLD       = 4'h0;
  localparam logic [3:0]  REG_LINE_CTRL  = 4'h3;
  localparam logic [3:0]  REG_MODEM_CTRL = 4'h4;
  localparam logic [3:0]  REG_LINE_STAT  = 4'h5;
  localparam logic [3:0]  REG_EXTRA_FEAT = 4'hF;
  localparam int          LCR_DIV_BIT    = 7;
  localparam logic [7:0]  LCR_ENHANCED   = 8'hBF;
  localparam int          MCR_IR_EN_BIT  = 6;
  localparam int          EXTRA_FEATURES_CTRL_IR11_BIT  = 7;
  localparam int          LSR_RX_READY   = 0;
  localparam int          LSR_TX_ROOM    = 5;
  localparam int          LSR_TX_EMPTY   = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  HOLD_RST  = 8'h00;
  localparam logic [7:0]  DLL_RST   = 8'h01;
  localparam logic [7:0]  LCR_RST   = 8'h00;
  localparam logic [7:0]  MCR_RST   = 8'h00;
  localparam logic [7:0]  EXTRA_FEATURES_CTRL_RST  = 8'h00;
  localparam logic [7:0]  READ_NONE = 8'h00;

  // ----------------------------------------------------------------
  // Queues, synchronisers, infrared timing
  // ----------------------------------------------------------------
  localparam int          DATA_W       = 8;
  localparam int          FIFO_DEPTH   = 64;
  localparam int          NUM_PINS     = 5;
  localparam int          PIN_SCLK     = 0;
  localparam int          PIN_CS_N     = 1;
  localparam int          PIN_SI       = 2;
  localparam int          PIN_IR_RX    = 3;
  localparam int          PIN_STRAP    = 4;
  localparam logic [4:0]  PIN_IDLE     = 5'h12;
  localparam logic [2:0]  STRAP_SETTLE = 3'h4;
  localparam logic [4:0]  TICKS_PER_BIT = 5'h10;
  localparam logic [3:0]  IR10_PULSE    = 4'h3;
  localparam logic [3:0]  IR11_PULSE    = 4'h4;

endpackage : suif_pkg

`default_nettype wire

/* File: rtl/suif_fifo.sv */
// Flip-flop queue with valid/ready on both sides and a synchronous flush.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
`default_nettype none

module suif_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      cnt_r    <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : suif_fifo

`default_nettype wire

/* File: rtl/suif_irda_codec.sv */
// Infrared pulse encoder and decoder on a 16x baud tick from the divisor.
// Assumes rxd_pin is already synchronised to clk by the caller.
`default_nettype none

module suif_irda_codec (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ir_en,
  input  wire logic        ir11_sel,
  input  wire logic [15:0] divisor,
  input  wire logic        uart_txd,
  output logic             txd_pin,
  input  wire logic        rxd_pin,
  output logic             uart_rxd,
  output logic             bit_stream
);

  logic [15:0] div_cnt_r;
  logic [3:0]  enc_ph_r;
  logic        txd_prev_r;
  logic        txd_pin_r;
  logic        rxd_prev_r;
  logic [4:0]  dec_cnt_r;
  logic        stream_r;
  logic        uart_rxd_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [15:0] div_eff    = (divisor == 16'h0000) ? 16'h0001 : divisor;
  wire        tick       = (div_cnt_r >= div_eff - 16'h0001);
  wire        txd_change = (uart_txd != txd_prev_r);
  wire [3:0]  pulse_w    = ir11_sel ? suif_pkg::IR11_PULSE
                                    : suif_pkg::IR10_PULSE;
  wire        ir_pulse   = ~uart_txd & (txd_change | (enc_ph_r < pulse_w));
  wire        rx_rise    = rxd_pin & ~rxd_prev_r;
  wire        rx_light   = rx_rise | (dec_cnt_r != 5'h00);

  assign txd_pin    = txd_pin_r;
  assign uart_rxd   = uart_rxd_r;
  assign bit_stream = stream_r;

  // Sixteenth-of-bit tick generator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= 16'h0000;
    end else begin
      div_cnt_r <= tick ? 16'h0000 : div_cnt_r + 16'h0001;
    end
  end

  // Encoder phase restarts on every data edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_ph_r   <= 4'h0;
      txd_prev_r <= 1'b1;
      txd_pin_r  <= 1'b1;
    end else begin
      txd_prev_r <= uart_txd;
      enc_ph_r   <= txd_change ? {3'h0, tick} : enc_ph_r + {3'h0, tick};  // Edge cycle is phase 0
      txd_pin_r  <= ir_en ? ir_pulse : uart_txd;
    end
  end

  // Decoder stretches each light pulse over one bit time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_prev_r <= 1'b0;
      dec_cnt_r  <= 5'h00;
      stream_r   <= 1'b0;
      uart_rxd_r <= 1'b1;
    end else begin
      rxd_prev_r <= rxd_pin;
      if (ir_en && rx_rise) begin
        dec_cnt_r <= suif_pkg::TICKS_PER_BIT;
      end else if (tick && dec_cnt_r != 5'h00) begin
        dec_cnt_r <= dec_cnt_r - 5'h01;
      end
      stream_r   <= ir_en & rx_light;
      uart_rxd_r <= ir_en ? ~rx_light : rxd_pin;
    end
  end

endmodule : suif_irda_codec

`default_nettype wire

/* File: rtl/suif_frontend.sv */
// SPI slave front end of one UART channel: command byte, holding registers,
// divisor low byte, line/modem/extra control, queues and infrared codec.
// Assumes SPI mode 0 and a serial clock well below a quarter of ref_clk,
// since all pins are oversampled through three-stage synchronisers.
//
// Behaviour
// - Command bit 7: one reads, zero writes
// - Command bits 6:3 give register index
// - Bits 2:1 select channel; bit 0 reserved
// - Up to 64 queue bytes per select
// - Basic infrared: 3/16-bit pulse per zero
// - Fast infrared: quarter-bit pulse per zero
// - Modem control bit 6 enables infrared
// - Extra features bit 7 picks quarter-bit
// - Infrared transmit output idles low
// - Infrared receive input idles low
// - Each detected light pulse gives a zero (one on ir_bit_stream)
// - Low strap starts infrared; then bit 6
// - Receive read returns and removes oldest
// - Empty receive read returns meaningless value
// - Transmit write appends at queue tail
// - Transmit write when full is dropped
// - Holding registers need line control bit7 clear
// - Divisor low when bit7 set, not BF
// - Divisor low is low eight bits
// - Divisor low resets only at power-on
`default_nettype none

module suif_frontend (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       soft_reset,
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_si,
  output logic            spi_so,
  output logic            spi_so_oe,
  input  wire logic       infrared_strap_n,
  output logic [7:0]      tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  output logic            rx_ready,
  input  wire logic [7:0] divisor_high,
  output logic [7:0]      baud_divisor_low,
  input  wire logic       uart_txd,
  output logic            uart_rxd,
  output logic            ir_txd,
  input  wire logic       ir_rxd,
  output logic            ir_bit_stream,
  output logic            infrared_mode
);

  // ----------------------------------------------------------------
  // Types and functions
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b100
  } suif_state_t;

  // Line control opens the divisor window at offset zero
  function automatic logic div_window(input logic [7:0] line_control_reg);
    div_window = line_control_reg[suif_pkg::LCR_DIV_BIT];
  endfunction : div_window

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0]  sync_r [suif_pkg::NUM_PINS];
  logic [suif_pkg::NUM_PINS-1:0] clean_r;
  logic [suif_pkg::NUM_PINS-1:0] clean_nxt;
  logic [suif_pkg::NUM_PINS-1:0] pins_in;

  suif_state_t state_r;
  suif_state_t state_nxt;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  shin_r;
  logic [7:0]  cmd_r;
  logic [7:0]  shout_r;
  logic        rd_pend_r;
  logic        pop_pend_r;

  logic [7:0]  lcr_r;
  logic [7:0]  mcr_r;
  logic [7:0]  extra_features_ctrl_r;
  logic [7:0]  dll_r;
  logic [2:0]  strap_cnt_r;
  logic        strap_done_r;

  logic        tx_in_ready;
  logic        tx_in_valid;
  logic        rx_out_valid;
  logic        rx_out_ready;
  logic [7:0]  rx_head;
  logic [7:0]  lsr;
  logic [7:0]  rd_data;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pins_in = {infrared_strap_n, ir_rxd, spi_si, spi_cs_n, spi_sclk};

  // Three stages; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < suif_pkg::NUM_PINS; g++) begin : g_sync
      assign clean_nxt[g] = (sync_r[g][1] == sync_r[g][2]) ? sync_r[g][2] : clean_r[g];
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync_r[g]  <= {3{suif_pkg::PIN_IDLE[g]}};
          clean_r[g] <= suif_pkg::PIN_IDLE[g];
        end else begin
          sync_r[g]  <= {sync_r[g][1:0], pins_in[g]};
          clean_r[g] <= clean_nxt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Serial framing decode
  // ----------------------------------------------------------------
  wire       cs_active = ~clean_r[suif_pkg::PIN_CS_N];
  wire       sclk_rise = clean_nxt[suif_pkg::PIN_SCLK] & ~clean_r[suif_pkg::PIN_SCLK];
  wire       sclk_fall = ~clean_nxt[suif_pkg::PIN_SCLK] & clean_r[suif_pkg::PIN_SCLK];
  wire [7:0] shin_byte = {shin_r[6:0], clean_nxt[suif_pkg::PIN_SI]};
  wire       byte_done = cs_active & sclk_rise & (bit_cnt_r == 3'h7);
  wire       cmd_done  = (state_r == ST_CMD) & byte_done;
  wire       data_done = (state_r == ST_DATA) & byte_done;

  // Command fields of the latched command byte
  wire       is_read = cmd_r[suif_pkg::CMD_RW_BIT];
  wire [3:0] reg_idx = cmd_r[suif_pkg::CMD_IDX_HI:suif_pkg::CMD_IDX_LO];
  wire       chan_ok = (cmd_r[suif_pkg::CMD_CH_HI:suif_pkg::CMD_CH_LO]
                        == suif_pkg::CH_A);
  wire       at_zero = chan_ok & (reg_idx == suif_pkg::REG_HOLD);
  wire       hold_sel = at_zero & ~div_window(lcr_r);
  wire       dll_sel  = at_zero & div_window(lcr_r)
                        & (lcr_r != suif_pkg::LCR_ENHANCED);
  wire       wr_fire  = data_done & ~is_read;
  wire       rd_load  = rd_pend_r & sclk_fall & cs_active;

  // Register strobes of a write byte
  wire wr_lcr  = wr_fire & chan_ok & (reg_idx == suif_pkg::REG_LINE_CTRL);
  wire wr_mcr  = wr_fire & chan_ok & (reg_idx == suif_pkg::REG_MODEM_CTRL);
  wire wr_extra_features_ctrl = wr_fire & chan_ok & (reg_idx == suif_pkg::REG_EXTRA_FEAT);
  wire wr_dll  = wr_fire & dll_sel;

  // ----------------------------------------------------------------
  // Transaction state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (!cs_active) begin
      state_nxt = ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: state_nxt = ST_CMD;
        ST_CMD:  state_nxt = cmd_done ? ST_DATA : ST_CMD;
        ST_DATA: state_nxt = ST_DATA;                     // Burst runs until deselect
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // State, bit counter and input shifter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      shin_r    <= 8'h00;
    end else begin
      state_r   <= state_nxt;
      bit_cnt_r <= (cs_active && state_r != ST_IDLE) ? bit_cnt_r + {2'h0, sclk_rise} : 3'h0;
      if (sclk_rise) begin
        shin_r <= shin_byte;
      end
    end
  end

  // Command latch
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= 8'h00;
    end else if (cmd_done) begin
      cmd_r <= shin_byte;
    end
  end

  // ----------------------------------------------------------------
  // Read path: load on falling edge, pop on first bit
  // ----------------------------------------------------------------
  wire cmd_is_read = shin_byte[suif_pkg::CMD_RW_BIT];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pend_r  <= 1'b0;
      pop_pend_r <= 1'b0;
      shout_r    <= 8'h00;
    end else if (!cs_active) begin
      rd_pend_r  <= 1'b0;
      pop_pend_r <= 1'b0;
      shout_r    <= 8'h00;
    end else begin
      if ((cmd_done && cmd_is_read) || (data_done && is_read)) begin
        rd_pend_r <= 1'b1;
      end else if (rd_load) begin
        rd_pend_r <= 1'b0;
      end
      if (rd_load) begin
        pop_pend_r <= hold_sel;
      end else if (sclk_rise) begin
        pop_pend_r <= 1'b0;
      end
      if (rd_load) begin
        shout_r <= rd_data;
      end else if (sclk_fall && state_r == ST_DATA) begin
        shout_r <= {shout_r[6:0], 1'b0};
      end
    end
  end

  // Pop only once the host really clocks the byte out
  assign rx_out_ready = pop_pend_r & sclk_rise & cs_active;

  // Line status view of the queues
  assign lsr = (8'h01 << suif_pkg::LSR_RX_READY) & {8{rx_out_valid}}
             | (8'h01 << suif_pkg::LSR_TX_ROOM) & {8{tx_in_ready}}
             | (8'h01 << suif_pkg::LSR_TX_EMPTY) & {8{~tx_valid}};

  // Read selection; empty receive queue yields a filler byte
  assign rd_data = hold_sel ? (rx_out_valid ? rx_head : suif_pkg::READ_NONE) :
                   !chan_ok ? suif_pkg::READ_NONE :
                   (reg_idx == suif_pkg::REG_LINE_CTRL)  ? lcr_r  :
                   (reg_idx == suif_pkg::REG_MODEM_CTRL) ? mcr_r  :
                   (reg_idx == suif_pkg::REG_LINE_STAT)  ? lsr    :
                   (reg_idx == suif_pkg::REG_EXTRA_FEAT) ? extra_features_ctrl_r :
                   suif_pkg::READ_NONE;

  assign spi_so    = shout_r[7];
  assign spi_so_oe = cs_active & (state_r == ST_DATA) & is_read;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Full queue refuses the push, so the byte is lost
  assign tx_in_valid = wr_fire & hold_sel;

  // Divisor low byte survives soft reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dll_r <= suif_pkg::DLL_RST;
    end else if (wr_dll) begin
      dll_r <= shin_byte;
    end
  end

  // Line and extra features control
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lcr_r  <= suif_pkg::LCR_RST;
      extra_features_ctrl_r <= suif_pkg::EXTRA_FEATURES_CTRL_RST;
    end else if (soft_reset) begin
      lcr_r  <= suif_pkg::LCR_RST;
      extra_features_ctrl_r <= suif_pkg::EXTRA_FEATURES_CTRL_RST;
    end else begin
      if (wr_lcr) begin
        lcr_r <= shin_byte;
      end
      if (wr_extra_features_ctrl) begin
        extra_features_ctrl_r <= shin_byte;
      end
    end
  end

  // Strap settle counter after power-on release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_r  <= 3'h0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r  <= strap_cnt_r + 3'h1;
      strap_done_r <= (strap_cnt_r == suif_pkg::STRAP_SETTLE);
    end
  end

  // Modem control; strap seeds the infrared enable once
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mcr_r <= suif_pkg::MCR_RST;
    end else if (soft_reset) begin
      mcr_r <= suif_pkg::MCR_RST;
    end else if (wr_mcr) begin
      mcr_r <= shin_byte;
    end else if (!strap_done_r && strap_cnt_r == suif_pkg::STRAP_SETTLE) begin
      mcr_r[suif_pkg::MCR_IR_EN_BIT] <= ~clean_r[suif_pkg::PIN_STRAP];
    end
  end

  assign baud_divisor_low = dll_r;
  assign infrared_mode    = mcr_r[suif_pkg::MCR_IR_EN_BIT];

  // ----------------------------------------------------------------
  // Queues and infrared codec
  // ----------------------------------------------------------------
  // Transmit queue towards the UART serialiser
  suif_fifo #(
    .WIDTH (suif_pkg::DATA_W),
    .DEPTH (suif_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (ref_clk),
    .rst_n     (reset_n),
    .flush     (soft_reset),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   (shin_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // Receive queue from the UART deserialiser
  suif_fifo #(
    .WIDTH (suif_pkg::DATA_W),
    .DEPTH (suif_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (ref_clk),
    .rst_n     (reset_n),
    .flush     (soft_reset),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready),
    .out_data  (rx_head)
  );

  // Infrared encode and decode on the line side
  suif_irda_codec u_irda (
    .clk        (ref_clk),
    .rst_n      (reset_n),
    .ir_en      (infrared_mode),
    .ir11_sel   (infrared_mode & extra_features_ctrl_r[suif_pkg::EXTRA_FEATURES_CTRL_IR11_BIT]),
    .divisor    ({divisor_high, dll_r}),
    .uart_txd   (uart_txd),
    .txd_pin    (ir_txd),
    .rxd_pin    (clean_r[suif_pkg::PIN_IR_RX]),
    .uart_rxd   (uart_rxd),
    .bit_stream (ir_bit_stream)
  );

endmodule : suif_frontend

`default_nettype wire

/* File: bench/suif_spi_host.sv */
// SPI host model: mode 0 master that drives the front end pins.
// Assumes pins change at the falling edge of the running ref_clk.
`default_nettype none

module suif_spi_host (
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // Select or release; select comes before any clocking
  task automatic frame(input logic on);
    @(negedge ref_clk);
    cs_n = !on;
    if (!on) si = ~si; // Released data line shows no stale level
    repeat (6) @(negedge ref_clk);
  endtask : frame

  // One byte MSB first, six ref_clk per half period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      repeat (6) @(negedge ref_clk);
      sclk  = 1'b1;
      rx[i] = so;
      repeat (6) @(negedge ref_clk);
      sclk = 1'b0;
    end
  endtask : xfer
endmodule : suif_spi_host

`default_nettype wire

/* File: bench/suif_frontend_assertions.sv */
// Port checker for the front end; bound to every suif_frontend.
// Assumes a divisor of one whenever infrared mode is on.
`default_nettype none

module suif_frontend_assertions (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       soft_reset,
  input wire logic       spi_cs_n,
  input wire logic       spi_so,
  input wire logic       spi_so_oe,
  input wire logic       infrared_strap_n,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] baud_divisor_low,
  input wire logic       uart_txd,
  input wire logic       ir_txd,
  input wire logic       ir_rxd,
  input wire logic       ir_bit_stream,
  input wire logic       infrared_mode
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_divisor_reset_value: assert property ($rose(reset_n) |-> baud_divisor_low == 8'h01)
    else $error("divisor low not 01 after reset");
  a_divisor_keeps_soft: assert property (soft_reset |=> $stable(baud_divisor_low))
    else $error("divisor low changed by soft reset");
  a_strap_starts_ir: assert property ($rose(reset_n) && !infrared_strap_n |-> ##7 infrared_mode)
    else $error("strap did not start infrared mode");
  a_ir_tx_idle: assert property ((infrared_mode && uart_txd)[*8] |-> !ir_txd)
    else $error("infrared output not idle low");
  a_ir_pulse_width: assert property ($rose(ir_txd) && infrared_mode |-> ##2 ir_txd ##[1:2] !ir_txd)
    else $error("infrared pulse width wrong");
  a_ir_decode_one: assert property (infrared_mode && $rose(ir_rxd) |-> ##[1:8] ir_bit_stream)
    else $error("light pulse not decoded");
  a_so_released: assert property (spi_cs_n[*6] |-> !spi_so_oe && !spi_so)
    else $error("slave output active while deselected");
  a_tx_stream_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit stream dropped while stalled");
endmodule : suif_frontend_assertions

bind suif_frontend suif_frontend_assertions suif_frontend_assertions_inst (
  .ref_clk, .reset_n, .soft_reset, .spi_cs_n, .spi_so, .spi_so_oe, .infrared_strap_n,
  .tx_data, .tx_valid, .tx_ready, .baud_divisor_low, .uart_txd, .ir_txd, .ir_rxd,
  .ir_bit_stream, .infrared_mode);

`default_nettype wire

/* File: bench/suif_frontend_tb_top.sv */
// Testbench: SPI accesses, queues, divisor low byte and infrared codec.
// Assumes the host model and bound checker.
`default_nettype none

module suif_frontend_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic       ref_clk = 1'b0, reset_n = 1'b0, soft_reset = 1'b0, tx_ready = 1'b0;
  logic       rx_valid = 1'b0, uart_txd = 1'b1, ir_rxd = 1'b0, strap_n = 1'b0;
  logic [7:0] rx_data = 8'h00, div_hi = 8'h00, tx_data, dll, r;
  logic       sclk, cs_n, si, so, tx_valid, rx_ready, uart_rxd, ir_txd, ir_bits, ir_mode, so_oe;
  int         errors = 0, checked = 0;

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #12.5 ref_clk = ~ref_clk;

  suif_frontend suif_frontend_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .soft_reset(soft_reset), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so),
    .spi_so_oe(so_oe), .infrared_strap_n(strap_n), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .divisor_high(div_hi), .baud_divisor_low(dll), .uart_txd(uart_txd), .uart_rxd(uart_rxd),
    .ir_txd(ir_txd), .ir_rxd(ir_rxd), .ir_bit_stream(ir_bits), .infrared_mode(ir_mode));

  suif_spi_host suif_spi_host_inst (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so(so));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Command byte then one data byte in one select
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    suif_spi_host_inst.frame(1'b1);
    suif_spi_host_inst.xfer(cmd, r);
    suif_spi_host_inst.xfer(d, r);
    suif_spi_host_inst.frame(1'b0);
  endtask : wr

  // One zero bit of 16 ticks; count high cycles on the line
  task automatic pulse(input logic [7:0] want);
    int n = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      uart_txd = (i >= 16);
      n += int'(ir_txd === 1'b1);
    end
    chk(8'(n), want);
  endtask : pulse

  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // Watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(dll, 8'h01);
    chk({7'h00, ir_mode}, 8'h01);
    pulse(8'd3);
    wr(8'h78, 8'h80);
    pulse(8'd4);
    chk({7'h00, ir_txd}, 8'h00);
    ir_rxd = 1'b1;
    repeat (3) @(negedge ref_clk);
    ir_rxd = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({6'h00, ir_bits, uart_rxd}, 8'h02);
    repeat (30) @(negedge ref_clk);
    chk({7'h00, uart_rxd}, 8'h01);
    wr(8'h20, 8'h00);
    chk({7'h00, ir_mode}, 8'h00);
    div_hi = 8'h01;
    pulse(8'd24);
    // Stalled burst of 65 bytes, then drain
    suif_spi_host_inst.frame(1'b1);
    suif_spi_host_inst.xfer(8'h00, r);
    for (int k = 0; k < 65; k++) suif_spi_host_inst.xfer(8'(k + 16), r);
    suif_spi_host_inst.frame(1'b0);
    for (int k = 0; k < 64; k++) begin
      @(negedge ref_clk);
      chk(tx_data, 8'(k + 16));
      tx_ready = 1'b1;
    end
    @(negedge ref_clk);
    tx_ready = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({7'h00, tx_valid}, 8'h00);
    // Three received bytes, read four in one burst
    for (int k = 0; k < 3; k++) begin
      rx_valid = 1'b1;
      rx_data  = 8'hA1 + 8'(k);
      @(negedge ref_clk);
    end
    rx_valid = 1'b0;
    chk({7'h00, rx_ready}, 8'h01);
    suif_spi_host_inst.frame(1'b1);
    suif_spi_host_inst.xfer(8'h80, r);
    chk({7'h00, so_oe}, 8'h01);
    for (int k = 0; k < 4; k++) begin
      suif_spi_host_inst.xfer(8'hFF, r);
      chk(r, (k < 3) ? 8'hA1 + 8'(k) : 8'h00);
    end
    suif_spi_host_inst.frame(1'b0);
    // Divisor low byte, soft reset, enhanced value, channel B
    wr(8'h18, 8'h80);
    wr(8'h00, 8'h5A);
    chk(dll, 8'h5A);
    soft_reset = 1'b1;
    @(negedge ref_clk);
    soft_reset = 1'b0;
    chk(dll, 8'h5A);
    wr(8'h18, 8'hBF);
    wr(8'h00, 8'h33);
    chk(dll, 8'h5A);
    wr(8'h18, 8'h00);
    wr(8'h02, 8'h77);
    chk({7'h00, tx_valid}, 8'h00);
    wr(8'h00, 8'hC3);
    chk(tx_data, 8'hC3);
    // Second power-on reset with the strap high
    strap_n = 1'b1;
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(dll, 8'h01);
    chk({7'h00, ir_mode}, 8'h00);
    final_report();
  end
endmodule : suif_frontend_tb_top

`default_nettype wire
